/* design/fwe_top.sv */
/*
  Flash write setup and error flag block: operand registers for the program
  engine, the read-clear error register, and an interrupt on new errors.
  Assumes an APB master on pclk and a program/erase engine that reports its
  result with single-cycle event strobes while busy is high.
*/
// Added by the designer: register access over APB.
// Functional notes
// R1: Software loads upper half of second data word before word, double or protect
// R2: Software writes address bits 15:2 to low address register before program
// R3: Software writes address bits 20:16 to high address register before program
// R4: Double program needs address bit 2 clear for eight-byte alignment
// R5: Error register only valid while lock low and all busy bits clear
// R6: Error register contents update when busy clears at operation end
// R7: Write-protect flag bit 8 set on program or erase of protected sector
// R8: Multi-sector erase skips protected sectors and raises write-protect flag
// R9: Bad resume aborts suspended operation and sets resume error bit 7
// R10: Inconsistent setup executes nothing and sets sequence error bit 6
// R11: One-over-zero bit 3 set when program tries raising a cleared bit
// R12: One-over-zero never raised while programming protection bits
// R13: Program error bit 2 set when a cell fails to program
// R14: Erase error bit 1 set when a cell fails to erase, fatal
// R15: Write error bit 0 set on any write error or invalid setup
// R16: Error flags stay set until software clears them
// R17: Reserved address and error bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module fwe_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Engine side
  input wire logic eng_busy,
  input wire logic eng_lock,
  input wire logic eng_protected,
  input wire logic eng_one_over_zero,
  input wire logic eng_program_fail,
  input wire logic eng_erase_fail,
  input wire logic eng_resume_fail,
  output logic eng_start,
  output logic [2:0] eng_op,
  output logic [20:0] eng_addr,
  output logic [15:0] eng_data_high
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [15:0] data_high_ff;
  logic [15:0] addr_low_ff;
  logic [15:0] addr_high_ff;
  logic [15:0] err_ff;
  logic [15:0] pend_ff;
  logic [15:0] irq_stat_ff;
  logic [15:0] irq_mask_ff;
  logic data_loaded_ff;
  logic addr_loaded_ff;
  logic busy_ff;
  logic [2:0] op_ff;
  logic [7:0] sel;
  logic unmapped;
  logic setup_ok;
  logic access;
  logic wr;
  logic rd;
  logic start_req;
  logic busy_fall;
  logic [15:0] ev;
  logic [15:0] nxt_pend;
  logic [15:0] rd_word;

  typedef enum logic [2:0] {
    FWE_IDLE = 3'b001,
    FWE_RUN = 3'b010,
    FWE_DONE = 3'b100
  } fwe_state_e;
  fwe_state_e state_ff;

  assign access = pclken && psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign start_req = wr && sel[6] && pwdata[3];

  fwe_apb_decode u_dec (
    .paddr(paddr),
    .sel(sel),
    .unmapped(unmapped)
  );

  fwe_setup_check u_chk (
    .op(pwdata[2:0]),
    .addr_low(addr_low_ff),
    .data_loaded(data_loaded_ff),
    .addr_loaded(addr_loaded_ff),
    .valid(setup_ok)
  );

  // ==========================================================================
  // APB handshake: no wait state, pready and prdata come from flops
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (pclken) begin
      pready <= psel && !penable;
    end
  end

  // Read mux; error register shows only defined bits
  always_comb begin
    rd_word = 16'h0000;
    if (sel[0]) begin
      rd_word = data_high_ff;
    end else if (sel[1]) begin
      rd_word = addr_low_ff & fwe_pkg::MASK_ADDR_LOW; // R17
    end else if (sel[2]) begin
      rd_word = addr_high_ff & fwe_pkg::MASK_ADDR_HIGH; // R17
    end else if (sel[3]) begin
      rd_word = err_ff & fwe_pkg::MASK_ERROR_FLAGS; // R17
    end else if (sel[4]) begin
      rd_word = irq_stat_ff;
    end else if (sel[5]) begin
      rd_word = irq_mask_ff;
    end else if (sel[6]) begin
      rd_word = {13'h0000, op_ff};
    end else if (sel[7]) begin
      rd_word = {13'h0000, eng_lock, busy_ff, state_ff == FWE_RUN}; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pclken) begin
      prdata <= {16'h0000, rd_word};
      pslverr <= psel && !penable && unmapped;
    end
  end

  // ==========================================================================
  // Operand registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_high_ff <= fwe_pkg::RST_DATA_W1_HIGH;
      addr_low_ff <= fwe_pkg::RST_ADDR_LOW;
      addr_high_ff <= fwe_pkg::RST_ADDR_HIGH;
    end else if (pclken && wr) begin
      if (sel[0]) begin
        data_high_ff <= pwdata[15:0]; // R1
      end
      if (sel[1]) begin
        addr_low_ff <= pwdata[15:0] & fwe_pkg::MASK_ADDR_LOW; // R2 R17
      end
      if (sel[2]) begin
        addr_high_ff <= pwdata[15:0] & fwe_pkg::MASK_ADDR_HIGH; // R3 R17
      end
    end
  end

  // Load tracking; consumed by each started operation so stale operands fail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_loaded_ff <= 1'b0;
      addr_loaded_ff <= 1'b0;
    end else if (pclken) begin
      if (wr && sel[0]) begin
        data_loaded_ff <= 1'b1;
      end else if (eng_start) begin
        data_loaded_ff <= 1'b0;
      end
      if (wr && (sel[1] || sel[2])) begin
        addr_loaded_ff <= 1'b1;
      end else if (eng_start) begin
        addr_loaded_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Operation sequencer
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FWE_IDLE;
      eng_start <= 1'b0;
      op_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else if (pclken) begin
      eng_start <= 1'b0;
      busy_ff <= eng_busy;
      case (state_ff)
        FWE_IDLE: begin
          if (start_req && setup_ok && !eng_lock) begin
            op_ff <= pwdata[2:0];
            eng_start <= 1'b1;
            state_ff <= FWE_RUN;
          end
        end
        FWE_RUN: begin
          if (busy_fall) begin
            state_ff <= FWE_DONE;
          end
        end
        FWE_DONE: begin
          state_ff <= FWE_IDLE;
        end
        default: begin
          state_ff <= FWE_IDLE;
        end
      endcase
    end
  end

  assign busy_fall = busy_ff && !eng_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_op <= 3'h0;
      eng_addr <= 21'h00_0000;
      eng_data_high <= 16'h0000;
    end else if (pclken) begin
      eng_op <= op_ff;
      eng_addr <= {addr_high_ff[4:0], addr_low_ff};
      eng_data_high <= data_high_ff;
    end
  end

  // ==========================================================================
  // Error events: engine faults pend while busy, posted when busy falls
  // ==========================================================================
  always_comb begin
    nxt_pend = pend_ff;
    if (state_ff == FWE_RUN) begin
      nxt_pend[fwe_pkg::BIT_WRITE_PROTECT] = pend_ff[fwe_pkg::BIT_WRITE_PROTECT] |
                                              eng_protected; // R7 R8
      nxt_pend[fwe_pkg::BIT_RESUME_ERR] = pend_ff[fwe_pkg::BIT_RESUME_ERR] |
                                           eng_resume_fail; // R9
      nxt_pend[fwe_pkg::BIT_ONE_OVER_ZERO] = pend_ff[fwe_pkg::BIT_ONE_OVER_ZERO] |
          (eng_one_over_zero && op_ff != fwe_pkg::FWE_OP_PROTECT); // R11 R12
      nxt_pend[fwe_pkg::BIT_PROGRAM_ERR] = pend_ff[fwe_pkg::BIT_PROGRAM_ERR] |
                                            eng_program_fail; // R13
      nxt_pend[fwe_pkg::BIT_ERASE_ERR] = pend_ff[fwe_pkg::BIT_ERASE_ERR] |
                                          eng_erase_fail; // R14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 16'h0000;
    end else if (pclken) begin
      pend_ff <= busy_fall ? 16'h0000 : nxt_pend;
    end
  end

  // Events landing this cycle; invalid setup posts at once, nothing runs
  always_comb begin
    ev = 16'h0000;
    if (busy_fall) begin
      ev = nxt_pend; // R6
    end
    if (start_req && !setup_ok) begin
      ev[fwe_pkg::BIT_SEQUENCE_ERR] = 1'b1; // R10
    end
    ev[fwe_pkg::BIT_WRITE_ERR] = |ev; // R15
  end

  // Sticky flags; a read clears only the bits it returned, so an event that
  // lands between the data capture and the access edge is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= fwe_pkg::RST_ERROR_FLAGS;
    end else if (pclken) begin
      if (rd && sel[3]) begin
        err_ff <= ((err_ff & ~prdata[15:0]) | ev) & fwe_pkg::MASK_ERROR_FLAGS; // R16
      end else begin
        err_ff <= (err_ff | ev) & fwe_pkg::MASK_ERROR_FLAGS; // R16 R17
      end
    end
  end

  // ==========================================================================
  // Interrupt: same layout as error flags, read-clear status, mask gated
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 16'h0000;
      irq_mask_ff <= 16'h0000;
      irq <= 1'b0;
    end else if (pclken) begin
      if (rd && sel[4]) begin
        irq_stat_ff <= ((irq_stat_ff & ~prdata[15:0]) | ev) & fwe_pkg::MASK_ERROR_FLAGS;
      end else begin
        irq_stat_ff <= (irq_stat_ff | ev) & fwe_pkg::MASK_ERROR_FLAGS;
      end
      if (wr && sel[5]) begin
        irq_mask_ff <= pwdata[15:0] & fwe_pkg::MASK_ERROR_FLAGS;
      end
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end
endmodule
`default_nettype wire

/* design/fwe_pkg.sv */
/*
  Package for the flash write setup and error flag block: register indices,
  field positions, reset values and engine operation codes.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package fwe_pkg;
  // ==========================================================================
  // Register indices (printed offsets are not all multiples of four)
  // ==========================================================================
  localparam logic [23:0] IDX_DATA_W1_HIGH = 24'h0e_000e;
  localparam logic [23:0] IDX_ADDR_LOW = 24'h0e_0010;
  localparam logic [23:0] IDX_ADDR_HIGH = 24'h0e_0012;
  localparam logic [23:0] IDX_ERROR_FLAGS = 24'h0e_0014;
  localparam logic [23:0] IDX_IRQ_STATUS = 24'h0e_0020;
  localparam logic [23:0] IDX_IRQ_MASK = 24'h0e_0021;
  localparam logic [23:0] IDX_ENGINE_CTRL = 24'h0e_0022;
  localparam logic [23:0] IDX_ENGINE_STAT = 24'h0e_0023;

  // ==========================================================================
  // Reset values and writable masks
  // ==========================================================================
  localparam logic [15:0] RST_DATA_W1_HIGH = 16'hffff;
  localparam logic [15:0] RST_ADDR_LOW = 16'h0000;
  localparam logic [15:0] RST_ADDR_HIGH = 16'h0000;
  localparam logic [15:0] RST_ERROR_FLAGS = 16'h0000;
  localparam logic [15:0] MASK_ADDR_LOW = 16'hfffc;
  localparam logic [15:0] MASK_ADDR_HIGH = 16'h001f;
  localparam logic [15:0] MASK_ERROR_FLAGS = 16'h01cf;

  // ==========================================================================
  // Error flag bit positions and the double-program address alignment bit
  // ==========================================================================
  localparam int BIT_WRITE_PROTECT = 8;
  localparam int BIT_RESUME_ERR = 7;
  localparam int BIT_SEQUENCE_ERR = 6;
  localparam int BIT_ONE_OVER_ZERO = 3;
  localparam int BIT_PROGRAM_ERR = 2;
  localparam int BIT_ERASE_ERR = 1;
  localparam int BIT_WRITE_ERR = 0;
  localparam int BIT_DOUBLE_ALIGN = 2;

  // ==========================================================================
  // Operation kinds issued to the engine
  // ==========================================================================
  typedef enum logic [2:0] {
    FWE_OP_WORD = 3'h0,
    FWE_OP_DOUBLE = 3'h1,
    FWE_OP_PROTECT = 3'h2,
    FWE_OP_ERASE = 3'h3,
    FWE_OP_RESUME = 3'h4
  } fwe_op_e;
endpackage

/* design/fwe_apb_decode.sv */
/*
  APB address decoder: maps a byte address to a one-hot register select.
  Assumes word-aligned accesses; anything else is reported unmapped.
*/
`timescale 1ns/1ps
`default_nettype none
module fwe_apb_decode (
  input wire logic [31:0] paddr,
  output logic [7:0] sel,
  output logic unmapped
);
  // ==========================================================================
  // Index compare, byte address is four times the index
  // ==========================================================================
  function automatic logic hit(input logic [31:0] a, input logic [23:0] idx);
    hit = (a == {6'h00, idx, 2'b00});
  endfunction

  always_comb begin
    sel = 8'h00;
    if (hit(paddr, fwe_pkg::IDX_DATA_W1_HIGH)) begin
      sel = 8'h01;
    end else if (hit(paddr, fwe_pkg::IDX_ADDR_LOW)) begin
      sel = 8'h02;
    end else if (hit(paddr, fwe_pkg::IDX_ADDR_HIGH)) begin
      sel = 8'h04;
    end else if (hit(paddr, fwe_pkg::IDX_ERROR_FLAGS)) begin
      sel = 8'h08;
    end else if (hit(paddr, fwe_pkg::IDX_IRQ_STATUS)) begin
      sel = 8'h10;
    end else if (hit(paddr, fwe_pkg::IDX_IRQ_MASK)) begin
      sel = 8'h20;
    end else if (hit(paddr, fwe_pkg::IDX_ENGINE_CTRL)) begin
      sel = 8'h40;
    end else if (hit(paddr, fwe_pkg::IDX_ENGINE_STAT)) begin
      sel = 8'h80;
    end
    unmapped = (sel == 8'h00);
  end
endmodule
`default_nettype wire

/* design/fwe_setup_check.sv */
/*
  Setup checker: decides whether the loaded operands form a valid request.
  Assumes the operation kind and operand registers are stable while checked.
*/
`timescale 1ns/1ps
`default_nettype none
module fwe_setup_check (
  input wire logic [2:0] op,
  input wire logic [15:0] addr_low,
  input wire logic data_loaded,
  input wire logic addr_loaded,
  output logic valid
);
  // ==========================================================================
  // Consistency of operands against operation kind
  // ==========================================================================
  always_comb begin
    case (op)
      fwe_pkg::FWE_OP_WORD: valid = data_loaded && addr_loaded; // R1 R2 R3
      fwe_pkg::FWE_OP_DOUBLE: valid = data_loaded && addr_loaded &&
                                      !addr_low[fwe_pkg::BIT_DOUBLE_ALIGN]; // R4
      fwe_pkg::FWE_OP_PROTECT: valid = data_loaded; // R1
      fwe_pkg::FWE_OP_ERASE: valid = 1'b1;
      fwe_pkg::FWE_OP_RESUME: valid = 1'b1;
      default: valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* tb/fwe_top_monitor.sv */
/* Checker for fwe_top: APB answer timing, engine start pulses, error reads.
   Assumes bind to fwe_top and pclken held high by the bench. */
`timescale 1ns/1ps
`default_nettype none
module fwe_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic eng_busy,
  input wire logic eng_lock,
  input wire logic eng_start
);
  localparam logic [31:0] A_ERR = {6'h00, fwe_pkg::IDX_ERROR_FLAGS, 2'b00};
  localparam logic [31:0] A_CTRL = {6'h00, fwe_pkg::IDX_ENGINE_CTRL, 2'b00};
  logic rd_err;
  logic wr_ctrl;
  // ==========================================================================
  // Accepted transfers
  assign rd_err = psel && penable && pready && !pwrite && paddr == A_ERR;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == A_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Error read after three idle engine cycles, so no engine fault can post meanwhile
  sequence s_quiet_rd;
    !eng_busy [*3] ##0 rd_err;
  endsequence
  AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SLVERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad refusal");
  AST_START_CAUSE: assert property (eng_start |-> $past(wr_ctrl))
    else $error("start without control write");
  AST_START_UNLOCKED: assert property (eng_start |-> !$past(eng_lock))
    else $error("start under lock");
  AST_START_PULSE: assert property (eng_start |=> !eng_start and !$past(eng_busy))
    else $error("start not a pulse");
  AST_ERR_RESERVED: assert property (rd_err |->
    prdata[31:9] == 23'h0 && prdata[5:4] == 2'h0)
    else $error("reserved error bits set");
  AST_ERR_SUMMARY: assert property (rd_err && (|prdata[8:1]) |-> prdata[0])
    else $error("summary bit missing");
  AST_ERR_STICKY: assert property (s_quiet_rd ##1 s_quiet_rd |-> prdata[15:0] == 16'h0000)
    else $error("error flags not cleared by read");
endmodule
bind fwe_top fwe_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .eng_busy(eng_busy), .eng_lock(eng_lock), .eng_start(eng_start));
`default_nettype wire

/* tb/fwe_engine_model.sv */
/* Flash array engine model: busy span after a start, fault strobes on command.
   Assumes the bench sets fault_cmd and hold before the start pulse. */
`timescale 1ns/1ps
`default_nettype none
module fwe_engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eng_start,
  input wire logic [4:0] fault_cmd,
  input wire logic [3:0] hold,
  output logic eng_busy,
  output logic eng_protected,
  output logic eng_one_over_zero,
  output logic eng_program_fail,
  output logic eng_erase_fail,
  output logic eng_resume_fail
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  logic [4:0] strobe_ff;
  // ==========================================================================
  // Strobes last only the first busy cycle, so the design must latch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      strobe_ff <= 5'h00;
    end else if (eng_start && !busy_ff) begin
      busy_ff <= 1'b1;
      cnt_ff <= hold;
      strobe_ff <= fault_cmd;
    end else if (busy_ff) begin
      strobe_ff <= 5'h00;
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h0) busy_ff <= 1'b0;
    end
  end
  // Fault lines
  assign eng_busy = busy_ff;
  assign eng_protected = strobe_ff[0];
  assign eng_one_over_zero = strobe_ff[1];
  assign eng_program_fail = strobe_ff[2];
  assign eng_erase_fail = strobe_ff[3];
  assign eng_resume_fail = strobe_ff[4];
endmodule
`default_nettype wire

/* tb/flash_write_setup_and_error_flags_bench.sv */
/* Self-checking bench for fwe_top with the engine model on its far side.
   Assumes APB answers by pready; pclken stays high throughout. */
`timescale 1ns/1ps
`default_nettype none
module flash_write_setup_and_error_flags_bench;
  localparam logic [31:0] A_DW = {6'h00, fwe_pkg::IDX_DATA_W1_HIGH, 2'b00};
  localparam logic [31:0] A_AL = {6'h00, fwe_pkg::IDX_ADDR_LOW, 2'b00};
  localparam logic [31:0] A_AH = {6'h00, fwe_pkg::IDX_ADDR_HIGH, 2'b00};
  localparam logic [31:0] A_ER = {6'h00, fwe_pkg::IDX_ERROR_FLAGS, 2'b00};
  localparam logic [31:0] A_IS = {6'h00, fwe_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [31:0] A_IM = {6'h00, fwe_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [31:0] A_EC = {6'h00, fwe_pkg::IDX_ENGINE_CTRL, 2'b00};
  localparam logic [31:0] A_ES = {6'h00, fwe_pkg::IDX_ENGINE_STAT, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
  logic eng_busy, eng_lock, eng_prot, eng_ooz, eng_pgf, eng_erf, eng_rsf, eng_start;
  logic [31:0] paddr, pwdata, prdata, rdv, r;
  logic [2:0] eng_op;
  logic [20:0] eng_addr;
  logic [15:0] eng_data_high, mask;
  logic [4:0] fault_cmd;
  logic [3:0] hold;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 97571;
  int starts = 0;
  int i;
  fwe_top DUT (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .eng_busy(eng_busy), .eng_lock(eng_lock),
    .eng_protected(eng_prot), .eng_one_over_zero(eng_ooz), .eng_program_fail(eng_pgf),
    .eng_erase_fail(eng_erf), .eng_resume_fail(eng_rsf), .eng_start(eng_start),
    .eng_op(eng_op), .eng_addr(eng_addr), .eng_data_high(eng_data_high));
  fwe_engine_model u_eng (.pclk(pclk), .presetn(presetn), .eng_start(eng_start),
    .fault_cmd(fault_cmd), .hold(hold), .eng_busy(eng_busy), .eng_protected(eng_prot),
    .eng_one_over_zero(eng_ooz), .eng_program_fail(eng_pgf), .eng_erase_fail(eng_erf),
    .eng_resume_fail(eng_rsf));
  // ==========================================================================
  // Clock and start counter
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (eng_start === 1'b1) starts <= starts + 1;
  end
  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait assumed; only the watchdog ends a stuck transfer
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rdv, e);
  endtask
  // Flags one finished operation should leave behind
  function automatic logic [15:0] exp_flags(input logic [2:0] op, input logic [4:0] f);
    logic [15:0] e;
    e = 16'h0000;
    e[fwe_pkg::BIT_WRITE_PROTECT] = f[0];
    e[fwe_pkg::BIT_ONE_OVER_ZERO] = f[1] && op != fwe_pkg::FWE_OP_PROTECT;
    e[fwe_pkg::BIT_PROGRAM_ERR] = f[2];
    e[fwe_pkg::BIT_ERASE_ERR] = f[3];
    e[fwe_pkg::BIT_RESUME_ERR] = f[4];
    e[fwe_pkg::BIT_WRITE_ERR] = |e;
    return e;
  endfunction
  // Load operands, launch, wait for the engine, then check flags and interrupt
  task automatic run_op(input logic [2:0] op, input logic ld, input logic b2,
                        input logic [4:0] f);
    logic [15:0] dh, al, ah, e;
    logic ok, seen;
    int s0, k;
    r = $random(seed);
    dh = r[31:16];
    al = {r[15:3], b2, 2'b00};
    ah = {11'h000, r[20:16]};
    if (ld) begin
      apb(1'b1, A_DW, {16'h0000, dh});
      apb(1'b1, A_AL, {16'h0000, al});
      apb(1'b1, A_AH, {16'h0000, ah});
    end
    ok = !eng_lock && (op >= 3'h3 || (ld && !(op == 3'h1 && b2)));
    e = ok ? exp_flags(op, f) : (eng_lock ? 16'h0000 : 16'h0041);
    fault_cmd <= f;
    hold <= r[3:0];
    s0 = starts;
    seen = 1'b0;
    apb(1'b1, A_EC, {28'h0000_000, 1'b1, op});
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (seen && eng_busy === 1'b0) break;
      // Operands shown on the first busy cycle; data only when this run loaded it
      if (eng_busy === 1'b1 && !seen) begin
        check({29'h0, eng_op}, {29'h0, op});
        if (op <= 3'h1) check({11'h0, eng_addr}, {11'h0, ah[4:0], al});
        if (ld) check({16'h0, eng_data_high}, {16'h0, dh});
      end
      if (eng_busy === 1'b1) seen = 1'b1;
    end
    repeat (3) @(posedge pclk);
    check(starts - s0, {31'h0, ok});
    check({31'h0, irq}, {31'h0, |(e & mask)});
    rd_chk(A_ER, {16'h0000, e});
    rd_chk(A_ER, 32'h0000_0000);
    rd_chk(A_IS, {16'h0000, e});
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog at 30000 cycles, far beyond the expected thousand or so cycles
  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, eng_lock} = 5'h00;
    {paddr, pwdata, fault_cmd, hold, mask} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_DW, 32'h0000_ffff);
    rd_chk(A_AL, 32'h0000_0000);
    rd_chk(A_AH, 32'h0000_0000);
    rd_chk(A_ER, 32'h0000_0000);
    rd_chk(32'h0038_00fc, 32'h0000_0000);
    check({31'h0, slv}, 32'h0000_0001);
    apb(1'b1, A_ER, 32'hffff_ffff);
    rd_chk(A_ER, 32'h0000_0000);
    run_op(3'h0, 1'b0, 1'b0, 5'h00);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      apb(1'b1, A_DW, r);
      rd_chk(A_DW, {16'h0000, r[15:0]});
      apb(1'b1, A_AL, r);
      rd_chk(A_AL, {16'h0000, r[15:0] & 16'hfffc});
      apb(1'b1, A_AH, r);
      rd_chk(A_AH, {16'h0000, r[15:0] & 16'h001f});
    end
    run_op(3'h1, 1'b1, 1'b1, 5'h00);
    for (i = 0; i < 5; i++) run_op(3'h0, 1'b1, 1'b0, 5'h01 << i);
    run_op(3'h1, 1'b1, 1'b0, 5'h04);
    run_op(3'h2, 1'b1, 1'b0, 5'h02);
    run_op(3'h3, 1'b0, 1'b0, 5'h01);
    run_op(3'h4, 1'b0, 1'b0, 5'h10);
    eng_lock <= 1'b1;
    @(posedge pclk);
    run_op(3'h3, 1'b0, 1'b0, 5'h08);
    rd_chk(A_ES, 32'h0000_0004);
    eng_lock <= 1'b0;
    mask = 16'h01cf;
    apb(1'b1, A_IM, {16'h0000, mask});
    rd_chk(A_IM, {16'h0000, mask});
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      run_op(r[2:0] > 3'h4 ? 3'h0 : r[2:0], 1'b1, r[3], r[8:4]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
